// File: logic/aprs_pkg.sv
// Package: register map, field layout, timing and the standard rate table
package aprs_pkg;
	// Register offsets on the control port
	localparam logic [7:0] PRI_RATE_OFS = 8'h32;
	localparam logic [7:0] SEC_RATE_OFS = 8'h33;
	// Field positions inside both rate registers
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 2;
	localparam int TOL_BIT = 1;
	localparam int CUSTOM_BIT = 0;
	// Reset values
	localparam logic [7:0] PRI_RATE_RST = 8'h00;
	localparam logic [7:0] SEC_RATE_RST = 8'h00;
	// Writable bits of the secondary register; bit 0 reads back zero
	localparam logic [7:0] SEC_WR_MASK = 8'hfe;
	// Code zero requests automatic frame rate detection
	localparam logic [5:0] AUTO_CODE = 6'h00;
	localparam logic [5:0] CODE_LAST = 6'h28;
	// Register clock and detection tolerance in percent
	localparam int CLK_HZ = 20_000_000;
	localparam int TOL_TIGHT_PCT = 1;
	localparam int TOL_WIDE_PCT = 5;
	localparam int PCT_FULL = 100;
	// Frame period counter width; 3 kHz at 20 MHz needs about 6700 cycles
	localparam int PERIOD_W = 16;
	localparam int RATE_W = 20;

	// Rate entry: {nominal, lowest accepted, highest accepted}; all zero when reserved
	function automatic logic [3*RATE_W-1:0] rate_entry(input logic [5:0] code);
		logic [3*RATE_W-1:0] e;
		e = '0;
		unique case (code)
			6'h01: e = {20'd768000, 20'd670320, 20'd791040};
			6'h02: e = {20'd614400, 20'd536256, 20'd632832};
			6'h03: e = {20'd512000, 20'd446880, 20'd527360};
			6'h04: e = {20'd438857, 20'd383040, 20'd452022};
			6'h05: e = {20'd384000, 20'd335160, 20'd395520};
			6'h06: e = {20'd341333, 20'd297920, 20'd351573};
			6'h07: e = {20'd307200, 20'd268128, 20'd316416};
			6'h08: e = {20'd256000, 20'd223440, 20'd263680};
			6'h09: e = {20'd219429, 20'd191520, 20'd226011};
			6'h0a: e = {20'd192000, 20'd167580, 20'd197760};
			6'h0b: e = {20'd170667, 20'd148960, 20'd175786};
			6'h0c: e = {20'd153600, 20'd134064, 20'd158208};
			6'h0d: e = {20'd128000, 20'd111720, 20'd131840};
			6'h0e: e = {20'd109714, 20'd95760, 20'd113005};
			6'h0f: e = {20'd96000, 20'd83790, 20'd98880};
			6'h10: e = {20'd85333, 20'd74480, 20'd87893};
			6'h11: e = {20'd76800, 20'd67032, 20'd79104};
			6'h12: e = {20'd64000, 20'd55860, 20'd65920};
			6'h13: e = {20'd54857, 20'd47880, 20'd56502};
			6'h14: e = {20'd48000, 20'd41895, 20'd49440};
			6'h15: e = {20'd42667, 20'd37240, 20'd43946};
			6'h16: e = {20'd38400, 20'd33516, 20'd39552};
			6'h17: e = {20'd32000, 20'd27930, 20'd32960};
			6'h18: e = {20'd27429, 20'd23940, 20'd28251};
			6'h19: e = {20'd24000, 20'd20947, 20'd24720};
			6'h1a: e = {20'd21333, 20'd18620, 20'd21973};
			6'h1b: e = {20'd19200, 20'd16758, 20'd19776};
			6'h1c: e = {20'd16000, 20'd13965, 20'd16480};
			6'h1d: e = {20'd13714, 20'd11970, 20'd14125};
			6'h1e: e = {20'd12000, 20'd10473, 20'd12360};
			6'h1f: e = {20'd10667, 20'd9310, 20'd10986};
			6'h20: e = {20'd9600, 20'd8379, 20'd9888};
			6'h21: e = {20'd8000, 20'd6982, 20'd8240};
			6'h22: e = {20'd6857, 20'd5985, 20'd7062};
			6'h23: e = {20'd6000, 20'd5236, 20'd6180};
			6'h24: e = {20'd5333, 20'd4469, 20'd4944};
			6'h26: e = {20'd4000, 20'd3491, 20'd4120};
			6'h27: e = {20'd3429, 20'd2992, 20'd3531};
			6'h28: e = {20'd3000, 20'd2618, 20'd3090};
			default: e = '0;
		endcase
		return e;
	endfunction
endpackage

// File: logic/aprs_rate_detect.sv
// Frame rate detector: measures the frame sync period and matches a standard rate
`timescale 1ns/1ps
`default_nettype none
module aprs_rate_detect #(
	parameter int PERIOD_W = aprs_pkg::PERIOD_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fsync_i,
	input wire logic tol_wide_i,
	output logic [5:0] code_o,
	output logic lock_o
);
	typedef struct packed {
		logic prev;
		logic armed;
		logic [PERIOD_W-1:0] cnt;
		logic [5:0] code;
		logic lock;
	} aprs_det_t;

	aprs_det_t st;
	aprs_det_t next_st;
	logic [5:0] found;
	logic [PERIOD_W-1:0] period;

	// Search the table for the rate whose nominal lies within the selected tolerance of the measured rate
	function automatic logic [5:0] match(input logic [PERIOD_W-1:0] per, input logic wide);
		logic [5:0] res;
		logic [3*aprs_pkg::RATE_W-1:0] e;
		logic [47:0] prod;
		logic [47:0] lo;
		logic [47:0] hi;
		int tol;
		res = aprs_pkg::AUTO_CODE;
		tol = wide ? aprs_pkg::TOL_WIDE_PCT : aprs_pkg::TOL_TIGHT_PCT;
		lo = 48'(aprs_pkg::CLK_HZ) * 48'(aprs_pkg::PCT_FULL - tol);
		hi = 48'(aprs_pkg::CLK_HZ) * 48'(aprs_pkg::PCT_FULL + tol);
		for (int c = 1; c <= 40; c++) begin
			e = aprs_pkg::rate_entry(6'(c));
			prod = 48'(per) * 48'(e[3*aprs_pkg::RATE_W-1:2*aprs_pkg::RATE_W])
				* 48'(aprs_pkg::PCT_FULL);
			if (res == aprs_pkg::AUTO_CODE && e != '0 && prod >= lo && prod <= hi) begin
				res = 6'(c);
			end
		end
		return res;
	endfunction

	assign period = st.cnt + PERIOD_W'(1);
	assign found = match(period, tol_wide_i); // [RQ5]

	// Count cycles between rising frame edges and judge each full period
	always_comb begin
		next_st = st;
		next_st.prev = fsync_i;
		if (st.cnt != '1) begin
			next_st.cnt = st.cnt + PERIOD_W'(1);
		end else begin
			next_st.lock = 1'b0; // Frame clock stopped
			next_st.code = aprs_pkg::AUTO_CODE;
			next_st.armed = 1'b0;
		end
		if (fsync_i && !st.prev) begin
			next_st.cnt = '0;
			next_st.armed = 1'b1;
			if (st.armed && st.cnt != '1) begin
				next_st.code = found; // [RQ1] [RQ7]
				next_st.lock = (found != aprs_pkg::AUTO_CODE);
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign code_o = st.code;
	assign lock_o = st.lock;

	lock_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
		lock_o |-> (code_o != 6'h00 && code_o <= 6'h28))
		else $error("detector locked without a valid rate");
endmodule
`default_nettype wire

// File: logic/aprs_rate_select.sv
// Sample rate and clock setup registers for the two audio serial ports
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1 - Primary code in bits 7..2; zero means the device detects the rate itself.
// RQ2 - Codes 1 to 25 map to nominal rates 768000 down to 24000 Hz.
// RQ3 - Codes 30 to 40 map to low rates, code 40 is 3000 Hz.
// RQ4 - Codes 41 to 63 are reserved; software avoids them, device flags them invalid.
// RQ5 - Bit 1 picks detection tolerance: zero is 1 percent, one is 5 percent.
// RQ6 - Primary bit 0 selects automatic or manual clock setup.
// RQ7 - Secondary code in bits 7..2, zero detects, same mapping as primary.
// RQ8 - Secondary codes 26 to 29 give 21333, 19200, 16000, 13714 Hz.
// RQ9 - Secondary bit 0 is reserved, reads zero, written only as zero.
// RQ10 - Both registers reset to zero: auto detect, 1 percent, auto clocks.
// RQ11 - Primary codes 26 to 29 use secondary mapping; code 37 is reserved.
module aprs_rate_select (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic pri_fsync_i,
	input wire logic sec_fsync_i,
	output logic custom_clk_o,
	output logic [5:0] pri_rate_code_o,
	output logic pri_auto_o,
	output logic pri_tol_wide_o,
	output logic pri_valid_o,
	output logic [19:0] pri_nominal_o,
	output logic [19:0] pri_min_o,
	output logic [19:0] pri_max_o,
	output logic [5:0] sec_rate_code_o,
	output logic sec_auto_o,
	output logic sec_tol_wide_o,
	output logic sec_valid_o,
	output logic [19:0] sec_nominal_o,
	output logic [19:0] sec_min_o,
	output logic [19:0] sec_max_o
);
	localparam int RW = aprs_pkg::RATE_W;

	typedef struct packed {
		logic [7:0] pri_reg;
		logic [7:0] sec_reg;
		logic [7:0] rdata;
		logic wrote; // Set by the first write after reset
		logic custom;
		logic [1:0][5:0] code;
		logic [1:0] auto;
		logic [1:0] tol;
		logic [1:0] valid;
		logic [1:0][RW-1:0] nom;
		logic [1:0][RW-1:0] lo;
		logic [1:0][RW-1:0] hi;
	} aprs_main_t;

	aprs_main_t st;
	aprs_main_t next_st;
	logic [1:0] fsync;
	logic [1:0][5:0] det_code;
	logic [1:0] det_lock;
	logic [1:0][7:0] port_reg;

	assign fsync = {sec_fsync_i, pri_fsync_i};
	assign port_reg = {st.sec_reg, st.pri_reg};

	// One frame rate detector per serial port
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_det
			aprs_rate_detect #(
				.PERIOD_W(aprs_pkg::PERIOD_W)
			) u_det (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.fsync_i(fsync[g]),
				.tol_wide_i(port_reg[g][aprs_pkg::TOL_BIT]),
				.code_o(det_code[g]),
				.lock_o(det_lock[g])
			);
		end
	endgenerate

	// Register writes, reads and per-port rate resolution
	always_comb begin
		logic [5:0] prog;
		logic [5:0] eff;
		logic [3*RW-1:0] ent;
		logic ok;
		prog = '0;
		eff = '0;
		ent = '0;
		ok = 1'b0;
		next_st = st;
		next_st.wrote = st.wrote | reg_wr_i; // Marks the end of the reset defaults
		if (reg_wr_i && reg_addr_i == aprs_pkg::PRI_RATE_OFS) begin
			next_st.pri_reg = reg_wdata_i; // [RQ1] [RQ5] [RQ6]
		end
		if (reg_wr_i && reg_addr_i == aprs_pkg::SEC_RATE_OFS) begin
			next_st.sec_reg = reg_wdata_i & aprs_pkg::SEC_WR_MASK; // [RQ7] [RQ9]
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				aprs_pkg::PRI_RATE_OFS: next_st.rdata = st.pri_reg;
				aprs_pkg::SEC_RATE_OFS: next_st.rdata = st.sec_reg; // [RQ9]
				default: next_st.rdata = 8'h00;
			endcase
		end
		next_st.custom = st.pri_reg[aprs_pkg::CUSTOM_BIT]; // [RQ6]
		for (int p = 0; p < 2; p++) begin
			prog = port_reg[p][aprs_pkg::CODE_MSB:aprs_pkg::CODE_LSB];
			next_st.auto[p] = (prog == aprs_pkg::AUTO_CODE); // [RQ1] [RQ7]
			eff = next_st.auto[p] ? det_code[p] : prog;
			// Reserved codes give an empty entry and so an invalid rate
			ent = aprs_pkg::rate_entry(eff); // [RQ2] [RQ3] [RQ4] [RQ8] [RQ11]
			ok = (ent != '0) && (!next_st.auto[p] || det_lock[p]);
			next_st.code[p] = eff;
			next_st.tol[p] = port_reg[p][aprs_pkg::TOL_BIT]; // [RQ5]
			next_st.valid[p] = ok;
			next_st.nom[p] = ok ? ent[3*RW-1:2*RW] : '0;
			next_st.lo[p] = ok ? ent[2*RW-1:RW] : '0;
			next_st.hi[p] = ok ? ent[RW-1:0] : '0;
		end
	end

	// State register; reset gives auto detect, tight tolerance, auto clocks
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
			st.pri_reg <= aprs_pkg::PRI_RATE_RST; // [RQ10]
			st.sec_reg <= aprs_pkg::SEC_RATE_RST; // [RQ10]
			st.auto <= 2'b11;
		end else begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state register
	assign reg_rdata_o = st.rdata;
	assign custom_clk_o = st.custom;
	assign pri_rate_code_o = st.code[0];
	assign pri_auto_o = st.auto[0];
	assign pri_tol_wide_o = st.tol[0];
	assign pri_valid_o = st.valid[0];
	assign pri_nominal_o = st.nom[0];
	assign pri_min_o = st.lo[0];
	assign pri_max_o = st.hi[0];
	assign sec_rate_code_o = st.code[1];
	assign sec_auto_o = st.auto[1];
	assign sec_tol_wide_o = st.tol[1];
	assign sec_valid_o = st.valid[1];
	assign sec_nominal_o = st.nom[1];
	assign sec_min_o = st.lo[1];
	assign sec_max_o = st.hi[1];

	// Write effects reach the outputs one edge after the taking edge; the checks sample them two edges after it
	pri_auto_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
		reg_wr_i && reg_addr_i == 8'h32 && reg_wdata_i[7:2] == 6'h00 |-> ##2 pri_auto_o)
		else $error("zero primary code did not select detection");

	code20_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
		reg_wr_i && reg_addr_i == 8'h32 && reg_wdata_i[7:2] == 6'h14 |-> ##2
		(pri_valid_o && pri_nominal_o == 20'd48000 && pri_min_o == 20'd41895
		&& pri_max_o == 20'd49440))
		else $error("code 20 rate window wrong");

	code40_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
		reg_wr_i && reg_addr_i == 8'h32 && reg_wdata_i[7:2] == 6'h28 |-> ##2
		(pri_nominal_o == 20'd3000 && pri_min_o == 20'd2618 && pri_max_o == 20'd3090))
		else $error("code 40 rate window wrong");

	reserved_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4] [RQ11]
		!pri_auto_o && (pri_rate_code_o > 6'h28 || pri_rate_code_o == 6'h25)
		|-> !pri_valid_o && pri_nominal_o == 20'd0)
		else $error("reserved code reported as valid");

	tol_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
		reg_wr_i && reg_addr_i == 8'h33 |-> ##2 sec_tol_wide_o == $past(reg_wdata_i[1], 2))
		else $error("tolerance select not applied");

	custom_clk_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
		reg_wr_i && reg_addr_i == 8'h32 ##1 !(reg_wr_i && reg_addr_i == 8'h32)
		|-> ##1 custom_clk_o == $past(reg_wdata_i[0], 2))
		else $error("clock setup bit not applied");

	sec_code27_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7] [RQ8]
		reg_wr_i && reg_addr_i == 8'h33 && reg_wdata_i[7:2] == 6'h1b |-> ##2
		(sec_nominal_o == 20'd19200 && sec_min_o == 20'd16758 && sec_max_o == 20'd19776))
		else $error("secondary code 27 rate window wrong");

	sec_bit0_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ9]
		reg_rd_i && reg_addr_i == 8'h33 |=> reg_rdata_o[0] == 1'b0)
		else $error("reserved secondary bit reads nonzero");

	reset_state_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
		!st.wrote |-> pri_auto_o && sec_auto_o && !custom_clk_o && !pri_tol_wide_o
		&& !sec_tol_wide_o)
		else $error("state after reset is not the default");

	pri_tol_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
		reg_wr_i && reg_addr_i == 8'h32 |-> ##2 pri_tol_wide_o == $past(reg_wdata_i[1], 2))
		else $error("primary tolerance select not applied");

	sec_auto_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
		reg_wr_i && reg_addr_i == 8'h33 && reg_wdata_i[7:2] == 6'h00 |-> ##2 sec_auto_o)
		else $error("zero secondary code did not select detection");

	sec_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4] [RQ11]
		!sec_auto_o && (sec_rate_code_o > 6'h28 || sec_rate_code_o == 6'h25)
		|-> !sec_valid_o && sec_nominal_o == 20'd0)
		else $error("reserved secondary code reported as valid");

	// A secondary write never reaches the clock setup bit
	sec_keeps_custom_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6] [RQ9]
		reg_wr_i && reg_addr_i == 8'h33 |-> ##2 $stable(custom_clk_o))
		else $error("secondary write changed the clock setup bit");

	auto_lock_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
		pri_auto_o && pri_valid_o |-> pri_rate_code_o != 6'h00 && pri_nominal_o != 20'd0)
		else $error("detected primary rate is empty");
endmodule
`default_nettype wire

// File: tb/aprs_fsync_host.sv
// Host-side frame sync source for one audio serial port
`timescale 1ns/1ps
`default_nettype none
module aprs_fsync_host (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic [15:0] period_i,
	output logic fsync_o
);
	logic [15:0] cnt;

	// Frame sync high for the first half of each frame, held low while stopped
	always_ff @(posedge clk_i) begin
		if (!run_i) begin
			cnt <= 16'h0000;
			fsync_o <= 1'b0;
		end else begin
			cnt <= (cnt >= period_i - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
			fsync_o <= (cnt < (period_i >> 1));
		end
	end
endmodule
`default_nettype wire

// File: tb/test_aprs_rate_select.sv
// Self-checking bench for the port rate and clock setup registers
`timescale 1ns/1ps
`default_nettype none
module test_aprs_rate_select;
	logic clk_i, rst_i, reg_wr_i, reg_rd_i, pri_run, sec_run, pri_fsync, sec_fsync;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
	logic custom_clk_o, pri_auto_o, pri_tol_wide_o, pri_valid_o;
	logic sec_auto_o, sec_tol_wide_o, sec_valid_o;
	logic [5:0] pri_rate_code_o, sec_rate_code_o;
	logic [19:0] pri_nominal_o, pri_min_o, pri_max_o, sec_nominal_o, sec_min_o, sec_max_o;
	logic [15:0] pri_per, sec_per;
	int err_count, check_count, seed;
	int nom[0:40];

	aprs_rate_select i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .pri_fsync_i(pri_fsync), .sec_fsync_i(sec_fsync),
		.custom_clk_o(custom_clk_o), .pri_rate_code_o(pri_rate_code_o),
		.pri_auto_o(pri_auto_o), .pri_tol_wide_o(pri_tol_wide_o), .pri_valid_o(pri_valid_o),
		.pri_nominal_o(pri_nominal_o), .pri_min_o(pri_min_o), .pri_max_o(pri_max_o),
		.sec_rate_code_o(sec_rate_code_o), .sec_auto_o(sec_auto_o),
		.sec_tol_wide_o(sec_tol_wide_o), .sec_valid_o(sec_valid_o),
		.sec_nominal_o(sec_nominal_o), .sec_min_o(sec_min_o), .sec_max_o(sec_max_o));
	aprs_fsync_host i_pri_host (.clk_i(clk_i), .run_i(pri_run), .period_i(pri_per),
		.fsync_o(pri_fsync));
	aprs_fsync_host i_sec_host (.clk_i(clk_i), .run_i(sec_run), .period_i(sec_per),
		.fsync_o(sec_fsync));

	// Register clock, 50 ns period
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Compare one result and count it
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One write strobe, held up to the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clk_i);
		#1;
		reg_wr_i = 1'b0;
	endtask

	// One read strobe; data is registered at the taking edge
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_i);
		#1;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_i);
		#1;
		reg_rd_i = 1'b0;
		rd = reg_rdata_o;
	endtask

	// Spot windows of accepted rates, zero where not checked
	function automatic logic [39:0] win(input logic [5:0] c);
		case (c)
			6'h01: return {20'd670320, 20'd791040};
			6'h14: return {20'd41895, 20'd49440};
			6'h1b: return {20'd16758, 20'd19776};
			6'h24: return {20'd4469, 20'd4944};
			6'h28: return {20'd2618, 20'd3090};
			default: return 40'h0;
		endcase
	endfunction

	// Program one port and check its outputs; min and max only for the spot codes in win
	task automatic port(input bit s, input logic [5:0] c, input logic t, input logic k);
		logic [19:0] n;
		logic [39:0] w;
		n = (c <= 6'd40) ? 20'(nom[c]) : 20'h00000;
		w = win(c);
		wr(s ? 8'h33 : 8'h32, {c, t, k});
		repeat (3) @(posedge clk_i);
		#1;
		chk(s ? sec_rate_code_o : pri_rate_code_o, c);
		chk(s ? sec_auto_o : pri_auto_o, c == 6'h00);
		chk(s ? sec_tol_wide_o : pri_tol_wide_o, t);
		chk(s ? sec_valid_o : pri_valid_o, n != 20'h00000);
		chk(s ? sec_nominal_o : pri_nominal_o, n);
		if (!s) chk(custom_clk_o, k);
		if (w != 40'h0) begin
			chk(s ? sec_min_o : pri_min_o, w[39:20]);
			chk(s ? sec_max_o : pri_max_o, w[19:0]);
		end
		rd_reg(s ? 8'h33 : 8'h32);
		chk(rd, {c, t, k & !s});
	endtask

	// Wait for the primary port to lock, and the secondary too when both is set, bounded
	task automatic wait_valid(input bit both);
		for (int i = 0; i < 4000 && !(pri_valid_o === 1'b1 && (!both || sec_valid_o === 1'b1)); i++)
			@(posedge clk_i);
		#1;
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		seed = 67;
		err_count = 0;
		check_count = 0;
		{reg_wr_i, reg_rd_i, pri_run, sec_run} = 4'h0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		pri_per = 16'd417;
		sec_per = 16'd1042;
		nom = '{0, 768000, 614400, 512000, 438857, 384000, 341333, 307200, 256000, 219429,
			192000, 170667, 153600, 128000, 109714, 96000, 85333, 76800, 64000, 54857, 48000,
			42667, 38400, 32000, 27429, 24000, 21333, 19200, 16000, 13714, 12000, 10667, 9600,
			8000, 6857, 6000, 5333, 0, 4000, 3429, 3000};
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		chk(pri_auto_o, 1'b1);
		chk(sec_auto_o, 1'b1);
		chk(custom_clk_o, 1'b0);
		chk(pri_valid_o, 1'b0);
		rd_reg(8'h32);
		chk(rd, 8'h00);
		rd_reg(8'h33);
		chk(rd, 8'h00);
		$display("test reset values done");
		// Every code on both ports, random tolerance and low bit
		for (int i = 0; i < 64; i++) begin
			port(1'b0, 6'(i), 1'($random(seed)), 1'($random(seed)));
			port(1'b1, 6'(i), 1'($random(seed)), 1'($random(seed)));
		end
		$display("test code table done");
		// Unmapped address is ignored and reads zero
		port(1'b0, 6'h14, 1'b0, 1'b1);
		wr(8'h31, 8'hff);
		rd_reg(8'h31);
		chk(rd, 8'h00);
		rd_reg(8'h32);
		chk(rd, 8'h51);
		$display("test unmapped address done");
		// Automatic detection on both ports at 1 percent
		port(1'b0, 6'h00, 1'b0, 1'b0);
		port(1'b1, 6'h00, 1'b0, 1'b0);
		pri_run = 1'b1;
		sec_run = 1'b1;
		wait_valid(1'b1);
		chk(pri_rate_code_o, 6'h14);
		chk(pri_nominal_o, 20'd48000);
		chk(sec_rate_code_o, 6'h1b);
		chk(sec_nominal_o, 20'd19200);
		$display("test auto detection done");
		// A frame 3 percent fast fails at 1 percent and locks at 5 percent
		pri_per = 16'd405;
		repeat (3000) @(posedge clk_i);
		#1;
		chk(pri_valid_o, 1'b0);
		wr(8'h32, 8'h02);
		wait_valid(1'b0);
		chk(pri_valid_o, 1'b1);
		chk(pri_rate_code_o, 6'h14);
		$display("test tolerance done");
		// Reset in mid-run brings back the defaults while frames keep running
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		chk(pri_auto_o, 1'b1);
		chk(pri_tol_wide_o, 1'b0);
		chk(pri_valid_o, 1'b0);
		rd_reg(8'h32);
		chk(rd, 8'h00);
		$display("test mid-run reset done");
		report_and_stop;
	end

	// Watchdog against a hang
	initial begin
		#2_000_000;
		err_count++;
		$display("watchdog expired");
		report_and_stop;
	end
endmodule
`default_nettype wire
